// file: src/iwc_interrupt_flag_wakeup_control.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module iwc_interrupt_flag_wakeup_control (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [7:0] timerACount,
  input wire logic directTransitionEvent,
  input wire logic [7:0] requestEvents,
  // wake pins
  input wire logic [7:0] wakePin,
  input wire logic [7:0] wakePinSelect,
  // requests to the processor
  output logic timerAIrq,
  output logic directTransitionIrq,
  output logic [7:0] otherRequestIrq,
  output logic wakeIrq,
  // module standby
  output logic serialUnitOneStandby,
  output logic eventCounterStandby,
  // noise filter strobe
  output logic noiseSampleStrobe
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setupPhase;
  logic accessPhase;
  logic writeTake;
  logic hitEnableOne;
  logic hitEnableTwo;
  logic hitRequestTwo;
  logic hitWakeFlags;
  logic hitClockStop;
  logic hitNoiseCtrl;
  logic hitAny;
  logic [7:0] wdata;
  logic unmapped;

  always_comb begin
    setupPhase = psel && !penable;
    accessPhase = psel && penable;
    hitEnableOne = iwc_pkg::regHit(paddr, iwc_pkg::IDX_ENABLE_ONE);
    hitEnableTwo = iwc_pkg::regHit(paddr, iwc_pkg::IDX_ENABLE_TWO);
    hitRequestTwo = iwc_pkg::regHit(paddr, iwc_pkg::IDX_REQUEST_TWO);
    hitWakeFlags = iwc_pkg::regHit(paddr, iwc_pkg::IDX_WAKE_FLAGS);
    hitClockStop = iwc_pkg::regHit(paddr, iwc_pkg::IDX_CLOCK_STOP_ONE);
    hitNoiseCtrl = iwc_pkg::regHit(paddr, iwc_pkg::IDX_NOISE_CTRL);
    hitAny = hitEnableOne || hitEnableTwo || hitRequestTwo || hitWakeFlags
             || hitClockStop || hitNoiseCtrl;
    // unmapped writes are dropped and flagged with pslverr
    unmapped = accessPhase && !hitAny;
    writeTake = accessPhase && pwrite && hitAny;
    wdata = pwdata[7:0];
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = unmapped;

  // ****************************************************************
  // register strobes
  // ****************************************************************
  logic readTake;
  logic writeEnableOne;
  logic writeEnableTwo;
  logic writeRequestTwo;
  logic writeWakeFlags;
  logic writeClockStop;
  logic writeNoiseCtrl;

  always_comb begin
    // read data is picked up in setup so it already stands when pready is sampled
    readTake = setupPhase && !pwrite;
    writeEnableOne = writeTake && hitEnableOne;
    writeEnableTwo = writeTake && hitEnableTwo;
    writeRequestTwo = writeTake && hitRequestTwo;
    writeWakeFlags = writeTake && hitWakeFlags;
    writeClockStop = writeTake && hitClockStop;
    writeNoiseCtrl = writeTake && hitNoiseCtrl;
  end

  // ****************************************************************
  // timer A wrap detection
  // ****************************************************************
  logic [7:0] timerPrev_q;
  logic [7:0] timerPrev_d;
  logic timerWrap;

  always_comb begin
    timerPrev_d = timerACount;
    timerWrap = (timerPrev_q == iwc_pkg::TIMER_A_MAX) && (timerACount == iwc_pkg::TIMER_A_ZERO);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // starting at zero keeps reset release from faking a wrap
      timerPrev_q <= iwc_pkg::TIMER_A_ZERO;
    end else begin
      timerPrev_q <= timerPrev_d;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] enableOne_q;
  logic [7:0] enableOne_d;
  logic [7:0] enableTwo_q;
  logic [7:0] enableTwo_d;
  logic [7:0] clockStop_q;
  logic [7:0] clockStop_d;
  logic [7:0] noiseCtrl_q;
  logic [7:0] noiseCtrl_d;

  always_comb begin
    enableOne_d = enableOne_q;
    enableTwo_d = enableTwo_q;
    clockStop_d = clockStop_q;
    noiseCtrl_d = noiseCtrl_q;
    if (writeEnableOne) begin
      enableOne_d = wdata;
    end
    if (writeEnableTwo) begin
      enableTwo_d = wdata;
    end
    if (writeClockStop) begin
      clockStop_d = wdata;
    end
    if (writeNoiseCtrl) begin
      noiseCtrl_d = wdata & iwc_pkg::NOISE_CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enableOne_q <= iwc_pkg::RESET_ENABLE;
      enableTwo_q <= iwc_pkg::RESET_ENABLE;
      clockStop_q <= iwc_pkg::RESET_CLOCK_STOP;
      noiseCtrl_q <= iwc_pkg::RESET_NOISE_CTRL;
    end else begin
      enableOne_q <= enableOne_d;
      enableTwo_q <= enableTwo_d;
      clockStop_q <= clockStop_d;
      noiseCtrl_q <= noiseCtrl_d;
    end
  end

  // ****************************************************************
  // noise filter and wake edges
  // ****************************************************************
  logic sampleStrobe;
  logic [7:0] wakeFall;

  iwc_sample_strobe u_sample (
    .clk(clk),
    .reset(reset),
    .fastRate(noiseCtrl_q[iwc_pkg::BIT_NOISE_FAST]),
    .sampleStrobe(sampleStrobe)
  );

  iwc_wake_edge u_wake (
    .clk(clk),
    .reset(reset),
    .sampleStrobe(sampleStrobe),
    .wakePin(wakePin),
    .wakePinSelect(wakePinSelect),
    .fallEvent(wakeFall)
  );

  assign noiseSampleStrobe = sampleStrobe;

  // ****************************************************************
  // request flags
  // ****************************************************************
  logic [7:0] requestTwo_q;
  logic [7:0] requestTwo_d;
  logic [7:0] requestSet;

  always_comb begin
    requestSet = requestEvents & iwc_pkg::REQUEST_TWO_FLAG_MASK;
    requestSet[iwc_pkg::BIT_TIMER_A_FLAG] = timerWrap;
    requestSet[iwc_pkg::BIT_DIRECT_FLAG] = directTransitionEvent;
    requestTwo_d = iwc_pkg::clearOrSet(requestTwo_q, writeRequestTwo, wdata, requestSet)
                   & iwc_pkg::REQUEST_TWO_FLAG_MASK;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      requestTwo_q <= iwc_pkg::RESET_REQUEST;
    end else begin
      requestTwo_q <= requestTwo_d;
    end
  end

  // ****************************************************************
  // wakeup flags
  // ****************************************************************
  logic [7:0] wakeFlags_q;
  logic [7:0] wakeFlags_d;

  always_comb begin
    wakeFlags_d = iwc_pkg::clearOrSet(wakeFlags_q, writeWakeFlags, wdata, wakeFall);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wakeFlags_q <= iwc_pkg::RESET_WAKE_FLAGS;
    end else begin
      wakeFlags_q <= wakeFlags_d;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    if (hitEnableOne) begin
      readByte = enableOne_q;
    end else if (hitEnableTwo) begin
      readByte = enableTwo_q;
    end else if (hitRequestTwo) begin
      readByte = requestTwo_q;
    end else if (hitWakeFlags) begin
      readByte = wakeFlags_q;
    end else if (hitClockStop) begin
      readByte = clockStop_q;
    end else if (hitNoiseCtrl) begin
      readByte = noiseCtrl_q;
    end
    rdata_d = rdata_q;
    if (readTake) begin
      rdata_d = {24'h000000, readByte};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // ****************************************************************
  // request outputs
  // ****************************************************************
  logic timerAIrq_q;
  logic timerAIrq_d;
  logic directIrq_q;
  logic directIrq_d;
  logic [7:0] otherIrq_q;
  logic [7:0] otherIrq_d;
  logic wakeIrq_q;
  logic wakeIrq_d;

  always_comb begin
    timerAIrq_d = requestTwo_q[iwc_pkg::BIT_TIMER_A_FLAG]
                  && enableOne_q[iwc_pkg::BIT_TIMER_A_ENABLE];
    directIrq_d = requestTwo_q[iwc_pkg::BIT_DIRECT_FLAG]
                  && enableTwo_q[iwc_pkg::BIT_DIRECT_ENABLE];
    // remaining flags gated bit by bit
    otherIrq_d = requestTwo_q & enableTwo_q & iwc_pkg::REQUEST_TWO_FLAG_MASK;
    otherIrq_d[iwc_pkg::BIT_TIMER_A_FLAG] = 1'b0;
    otherIrq_d[iwc_pkg::BIT_DIRECT_FLAG] = 1'b0;
    wakeIrq_d = |wakeFlags_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timerAIrq_q <= 1'b0;
      directIrq_q <= 1'b0;
      otherIrq_q <= 8'h00;
      wakeIrq_q <= 1'b0;
    end else begin
      timerAIrq_q <= timerAIrq_d;
      directIrq_q <= directIrq_d;
      otherIrq_q <= otherIrq_d;
      wakeIrq_q <= wakeIrq_d;
    end
  end

  assign timerAIrq = timerAIrq_q;
  assign directTransitionIrq = directIrq_q;
  assign otherRequestIrq = otherIrq_q;
  assign wakeIrq = wakeIrq_q;

  // ****************************************************************
  // module standby
  // ****************************************************************
  logic serialStandby_q;
  logic serialStandby_d;
  logic counterStandby_q;
  logic counterStandby_d;

  always_comb begin
    serialStandby_d = !clockStop_q[iwc_pkg::BIT_SERIAL_ONE_RUN];
    counterStandby_d = !clockStop_q[iwc_pkg::BIT_EVENT_COUNTER_RUN];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      serialStandby_q <= 1'b0;
      counterStandby_q <= 1'b0;
    end else begin
      serialStandby_q <= serialStandby_d;
      counterStandby_q <= counterStandby_d;
    end
  end

  assign serialUnitOneStandby = serialStandby_q;
  assign eventCounterStandby = counterStandby_q;

endmodule // iwc_interrupt_flag_wakeup_control
`default_nettype wire

// file: src/iwc_pkg.sv
`default_nettype none
package iwc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_ENABLE_ONE = 10'h0f3;
  localparam logic [9:0] IDX_ENABLE_TWO = 10'h0f4;
  localparam logic [9:0] IDX_REQUEST_TWO = 10'h0f7;
  localparam logic [9:0] IDX_WAKE_FLAGS = 10'h0f9;
  localparam logic [9:0] IDX_CLOCK_STOP_ONE = 10'h0fa;
  localparam logic [9:0] IDX_NOISE_CTRL = 10'h0fb;
  localparam int ADDR_WIDTH = 12;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_TIMER_A_ENABLE = 6;
  localparam int BIT_DIRECT_ENABLE = 7;
  localparam int BIT_TIMER_A_FLAG = 6;
  localparam int BIT_DIRECT_FLAG = 7;
  localparam int BIT_SERIAL_ONE_RUN = 5;
  localparam int BIT_EVENT_COUNTER_RUN = 4;
  localparam int BIT_NOISE_FAST = 0;
  // request-two bits that are flags; bit 5 reads zero
  localparam logic [7:0] REQUEST_TWO_FLAG_MASK = 8'hdf;
  localparam logic [7:0] NOISE_CTRL_MASK = 8'h01;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_REQUEST = 8'h00;
  localparam logic [7:0] RESET_WAKE_FLAGS = 8'h00;
  localparam logic [7:0] RESET_CLOCK_STOP = 8'hff;
  localparam logic [7:0] RESET_NOISE_CTRL = 8'h00;
  localparam logic [7:0] TIMER_A_MAX = 8'hff;
  localparam logic [7:0] TIMER_A_ZERO = 8'h00;

  // ****************************************************************
  // noise filter sampling divisors of the oscillator clock
  // ****************************************************************
  localparam int NOISE_DIV_SLOW = 16;
  localparam int NOISE_DIV_FAST = 4;
  localparam logic [3:0] NOISE_LAST_SLOW = 4'(NOISE_DIV_SLOW - 1);
  localparam logic [3:0] NOISE_LAST_FAST = 4'(NOISE_DIV_FAST - 1);

  // word address hits a register index
  function automatic logic regHit(input logic [ADDR_WIDTH-1:0] addr, input logic [9:0] idx);
    regHit = (addr[1:0] == 2'h0) && (addr[ADDR_WIDTH-1:2] == idx);
  endfunction

  // write-zero-to-clear flags; a set in the same cycle wins
  function automatic logic [7:0] clearOrSet(input logic [7:0] flags, input logic wr,
                                            input logic [7:0] wdata, input logic [7:0] set);
    logic [7:0] clr;
    clr = wr ? ~wdata : 8'h00;
    clearOrSet = (flags & ~clr) | set;
  endfunction

endpackage
`default_nettype wire

// file: src/iwc_sample_strobe.sv
`timescale 1ns/1ps
`default_nettype none
module iwc_sample_strobe (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // rate select
  input wire logic fastRate,
  // sample strobe
  output logic sampleStrobe
);
  logic [3:0] divCount_q;
  logic [3:0] divCount_d;
  logic [3:0] lastCount;
  logic strobe_q;
  logic strobe_d;

  always_comb begin
    lastCount = fastRate ? iwc_pkg::NOISE_LAST_FAST : iwc_pkg::NOISE_LAST_SLOW;
    // a rate change mid-period restarts cleanly instead of running to 15
    if (divCount_q >= lastCount) begin
      divCount_d = 4'h0;
      strobe_d = 1'b1;
    end else begin
      divCount_d = divCount_q + 4'h1;
      strobe_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divCount_q <= 4'h0;
      strobe_q <= 1'b0;
    end else begin
      divCount_q <= divCount_d;
      strobe_q <= strobe_d;
    end
  end

  assign sampleStrobe = strobe_q;
endmodule // iwc_sample_strobe
`default_nettype wire

// file: src/iwc_wake_edge.sv
`timescale 1ns/1ps
`default_nettype none
module iwc_wake_edge (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sampling
  input wire logic sampleStrobe,
  // pins
  input wire logic [7:0] wakePin,
  input wire logic [7:0] wakePinSelect,
  // events
  output logic [7:0] fallEvent
);
  logic [7:0] sampleA_q;
  logic [7:0] sampleA_d;
  logic [7:0] stable_q;
  logic [7:0] stable_d;
  logic [7:0] fall_q;
  logic [7:0] fall_d;

  always_comb begin
    sampleA_d = sampleStrobe ? wakePin : sampleA_q;
    stable_d = stable_q;
    fall_d = 8'h00;
    if (sampleStrobe) begin
      // a level counts only after two equal samples, so short glitches are dropped
      stable_d = (sampleA_q & wakePin) | (stable_q & (sampleA_q ^ wakePin));
      fall_d = stable_q & ~stable_d & wakePinSelect;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sampleA_q <= 8'hff;
      stable_q <= 8'hff;
      fall_q <= 8'h00;
    end else begin
      sampleA_q <= sampleA_d;
      stable_q <= stable_d;
      fall_q <= fall_d;
    end
  end

  assign fallEvent = fall_q;
endmodule // iwc_wake_edge
`default_nettype wire

// file: test/iwc_flag_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module iwc_flag_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // sources and outputs
  input wire logic directTransitionEvent,
  input wire logic timerAIrq,
  input wire logic directTransitionIrq,
  input wire logic [7:0] otherRequestIrq,
  input wire logic wakeIrq,
  input wire logic serialUnitOneStandby,
  input wire logic eventCounterStandby,
  input wire logic noiseSampleStrobe
);
  // ****************************************
  // helpers
  // ****************************************
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a request may only drop or a standby change shortly after a write
  sequence wroteLately;
    $past(wrAcc, 1) || $past(wrAcc, 2) || $past(wrAcc, 3) || $past(wrAcc, 4);
  endsequence
  sequence quietGap;
    !noiseSampleStrobe [*3];
  endsequence
  // ****************************************
  // checks
  // ****************************************
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  timer_drop_a: assert property ($fell(timerAIrq) |-> wroteLately)
    else $error("timer request dropped without a write");
  direct_drop_a: assert property ($fell(directTransitionIrq) |-> wroteLately)
    else $error("direct request dropped without a write");
  wake_drop_a: assert property ($fell(wakeIrq) |-> wroteLately)
    else $error("wake request dropped without a write");
  direct_rise_a: assert property ($rose(directTransitionIrq) |->
    ($past(directTransitionEvent, 1) || $past(directTransitionEvent, 2)) or wroteLately)
    else $error("direct request rose without cause");
  upper_quiet_a: assert property (otherRequestIrq[7:5] == 3'h0)
    else $error("unused request bits active");
  standby_write_a: assert property
    ($changed({serialUnitOneStandby, eventCounterStandby}) |-> wroteLately)
    else $error("standby changed without a write");
  strobe_gap_a: assert property (noiseSampleStrobe |=> quietGap)
    else $error("sample strobes too close");
endmodule // iwc_flag_monitor
`default_nettype wire

// file: test/tb_iwc_interrupt_flag_wakeup_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_iwc_interrupt_flag_wakeup_control;
  // ****************************************
  // signals
  // ****************************************
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] timerACount, requestEvents, wakePin, wakePinSelect, otherRequestIrq;
  logic directTransitionEvent, timerAIrq, directTransitionIrq, wakeIrq;
  logic serialUnitOneStandby, eventCounterStandby, noiseSampleStrobe;
  int numErrors = 0;
  int cmpCount = 0;
  int cycles = 0;
  localparam int LIMIT = 6000;
  localparam logic [9:0] EN1 = iwc_pkg::IDX_ENABLE_ONE;
  localparam logic [9:0] EN2 = iwc_pkg::IDX_ENABLE_TWO;
  localparam logic [9:0] REQ = iwc_pkg::IDX_REQUEST_TWO;
  localparam logic [9:0] WAKE = iwc_pkg::IDX_WAKE_FLAGS;
  localparam logic [9:0] STOP = iwc_pkg::IDX_CLOCK_STOP_ONE;
  localparam logic [9:0] NOISE = iwc_pkg::IDX_NOISE_CTRL;

  iwc_interrupt_flag_wakeup_control iwc_interrupt_flag_wakeup_control_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerACount(timerACount), .directTransitionEvent(directTransitionEvent),
    .requestEvents(requestEvents), .wakePin(wakePin), .wakePinSelect(wakePinSelect),
    .timerAIrq(timerAIrq), .directTransitionIrq(directTransitionIrq),
    .otherRequestIrq(otherRequestIrq), .wakeIrq(wakeIrq),
    .serialUnitOneStandby(serialUnitOneStandby), .eventCounterStandby(eventCounterStandby),
    .noiseSampleStrobe(noiseSampleStrobe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      numErrors++;
      stop_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ev is pulsed on requestEvents exactly at the access edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [7:0] ev);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    requestEvents <= ev;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    requestEvents <= 8'h00;
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, 8'h00);
    check(rd, exp);
  endtask

  // period between strobes, after two strobes to let a rate change settle
  task automatic period(input logic [7:0] sel, input int exp);
    int n;
    apb(1'b1, NOISE, sel, 8'h00);
    repeat (3) begin
      n = 1;
      @(posedge clk);
      while (noiseSampleStrobe !== 1'b1 && n < 40) begin
        n++;
        @(posedge clk);
      end
    end
    check(n, exp);
  endtask

  task automatic t_reset;
    rdchk(EN1, 32'h0);
    rdchk(EN2, 32'h0);
    rdchk(REQ, 32'h0);
    rdchk(WAKE, 32'h0);
    rdchk(STOP, 32'hff);
    rdchk(NOISE, 32'h0);
    check({serialUnitOneStandby, eventCounterStandby}, 32'h0);
    apb(1'b0, 10'h0f0, 8'h00, 8'h00);
    check(rd, 32'h0);
    check(err, 32'h1);
    $display("reset test done");
  endtask

  task automatic t_timer;
    timerACount <= 8'hff;
    cyc(1);
    timerACount <= 8'h00;
    cyc(3);
    rdchk(REQ, 32'h40);
    check(timerAIrq, 32'h0);
    apb(1'b1, EN1, 8'h40, 8'h00);
    cyc(3);
    check(timerAIrq, 32'h1);
    apb(1'b1, REQ, 8'hff, 8'h00);
    rdchk(REQ, 32'h40);
    apb(1'b1, REQ, 8'hbf, 8'h00);
    cyc(3);
    check(timerAIrq, 32'h0);
    rdchk(REQ, 32'h0);
    apb(1'b1, EN1, 8'h00, 8'h00);
    $display("timer test done");
  endtask

  task automatic t_direct;
    @(posedge clk);
    directTransitionEvent <= 1'b1;
    @(posedge clk);
    directTransitionEvent <= 1'b0;
    cyc(3);
    check(directTransitionIrq, 32'h0);
    apb(1'b1, REQ, 8'hff, 8'hff);
    rdchk(REQ, 32'h9f);
    apb(1'b1, EN2, 8'h9f, 8'h00);
    cyc(3);
    check(directTransitionIrq, 32'h1);
    check(otherRequestIrq, 32'h1f);
    apb(1'b1, REQ, 8'h00, 8'h01);
    rdchk(REQ, 32'h01);
    apb(1'b1, REQ, 8'h00, 8'h00);
    cyc(3);
    check(otherRequestIrq, 32'h0);
    check(directTransitionIrq, 32'h0);
    @(posedge clk);
    directTransitionEvent <= 1'b1;
    @(posedge clk);
    directTransitionEvent <= 1'b0;
    cyc(3);
    check(directTransitionIrq, 32'h1);
    apb(1'b1, REQ, 8'h7f, 8'h00);
    rdchk(REQ, 32'h0);
    apb(1'b1, EN2, 8'h00, 8'h00);
    $display("direct test done");
  endtask

  task automatic t_wake;
    wakePinSelect <= 8'h0f;
    wakePin <= 8'h00;
    cyc(60);
    rdchk(WAKE, 32'h0f);
    check(wakeIrq, 32'h1);
    apb(1'b1, WAKE, 8'hfe, 8'h00);
    rdchk(WAKE, 32'h0e);
    apb(1'b1, WAKE, 8'h00, 8'h00);
    cyc(3);
    check(wakeIrq, 32'h0);
    rdchk(WAKE, 32'h0);
    wakePin <= 8'hff;
    period(8'h01, 4);
    period(8'h00, 16);
    $display("wake and filter test done");
  endtask

  task automatic t_standby;
    apb(1'b1, STOP, 8'h10, 8'h00);
    cyc(3);
    check({serialUnitOneStandby, eventCounterStandby}, 32'h2);
    apb(1'b1, STOP, 8'h20, 8'h00);
    cyc(3);
    check({serialUnitOneStandby, eventCounterStandby}, 32'h1);
    rdchk(STOP, 32'h20);
    apb(1'b1, STOP, 8'hff, 8'h00);
    $display("standby test done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timerACount = 8'h10;
    requestEvents = 8'h00;
    directTransitionEvent = 1'b0;
    wakePin = 8'hff;
    wakePinSelect = 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_timer();
    t_direct();
    t_wake();
    t_standby();
    stop_test();
  end
endmodule // tb_iwc_interrupt_flag_wakeup_control

bind iwc_interrupt_flag_wakeup_control iwc_flag_monitor iwc_flag_monitor_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .directTransitionEvent(directTransitionEvent),
  .timerAIrq(timerAIrq), .directTransitionIrq(directTransitionIrq),
  .otherRequestIrq(otherRequestIrq), .wakeIrq(wakeIrq),
  .serialUnitOneStandby(serialUnitOneStandby), .eventCounterStandby(eventCounterStandby),
  .noiseSampleStrobe(noiseSampleStrobe)
);
`default_nettype wire
